// File: bench/fgc_host_model.sv
/*
  fgc_host_model: host side of the register port, with write and read tasks.
  Assumes the bench calls its tasks one at a time; drives on falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module fgc_host_model
  import fgc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o
);
  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  // idle values at time zero
  initial begin
    reg_addr_o = 8'hff;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // one-cycle write strobe, lines scrambled after release
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == FGC_CFG_ADDR) begin
      v[5] = 1'b0;
      if (v[FGC_B_TSRC]) v[FGC_B_THRM_ON] = 1'b1;
    end
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~v;
  endtask

  // one-cycle read strobe, data taken once it has settled
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(negedge clk_sys_i);
    d = reg_rdata_i;
  endtask
endmodule

`default_nettype wire

// File: bench/tb_fgc_config_alert.sv
/*
  tb_fgc_config_alert: self-checking bench for the configuration and alert block.
  Assumes the host model on the register port; short delay and task counts.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_fgc_config_alert;
  import fgc_pkg::*;
  localparam logic [63:0] THR_OFF = 64'hff00_7f80_ff00_7f80;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  fgc_meas_s meas = '0;
  fgc_thr_s thr = THR_OFF;
  logic sense = 1'b0;
  logic scl = 1'b1;
  logic sda = 1'b1;
  logic pin;
  logic oe_n;
  logic pd;
  logic tick;
  logic ext;
  logic htemp;
  logic ten;
  logic thm;
  logic bias;
  logic [9:0] flags;
  logic [15:0] v;
  int err_count = 0;
  int checks = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  fgc_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

  fgc_config_alert #(.PD_DELAY_CYC(32'd20), .TASK_CYC(32'd8)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .meas_i(meas),
    .thr_i(thr), .analog_sense_input_i(sense), .scl_i(scl), .sda_i(sda),
    .alert_pin_out_o(pin), .alert_pin_oe_n_o(oe_n), .power_down_o(pd),
    .task_tick_o(tick), .temp_source_ext_o(ext), .host_temp_o(htemp),
    .temp_measure_en_o(ten), .thermistor_measure_on_o(thm),
    .bias_switch_force_o(bias), .status_flags_o(flags));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits for a task tick, then for the flag update behind it
  task automatic wait_tick();
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (tick !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(n < 40), 16'h0001);
    @(negedge clk_sys_i);
    chk(16'(tick), 16'h0000);
  endtask

  // counts cycles until power_down_o reaches lvl, checks the window
  task automatic wait_pd(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (pd !== lvl && n < 100) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset values, reserved bit, unmapped address
  task automatic t_reset();
    rst_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk({13'h0, ten, pd, oe_n}, 16'h0001);
    host.rd(FGC_CFG_ADDR, v);
    chk(v, FGC_CFG_RST);
    host.wr(FGC_CFG_ADDR, 16'hff7f);
    host.rd(FGC_CFG_ADDR, v);
    chk(v, 16'hff5f);
    host.rd(8'h55, v);
    chk(v, 16'h0000);
    host.wr(FGC_CFG_ADDR, 16'h0000);
    $display("test reset done");
  endtask

  // control outputs follow the written bits at once
  task automatic t_outputs();
    logic [15:0] w [3] = '{16'h8200, 16'h0208, 16'h0300};
    logic [4:0] e [3] = '{5'b10110, 5'b00101, 5'b01000};
    for (int i = 0; i < 3; i++) begin
      host.wr(FGC_CFG_ADDR, w[i]);
      chk({11'h0, ext, htemp, ten, thm, bias}, {11'h0, e[i]});
    end
    $display("test outputs done");
  endtask

  // every maximum threshold kind, self-clearing then sticky with the pin enabled
  task automatic t_thresh();
    logic [15:0] stk [4] = '{16'h1000, 16'h2000, 16'h4000, 16'h0800};
    int fl [4] = '{FGC_F_VMX, FGC_F_TMX, FGC_F_SMX, FGC_F_IMX};
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 4; i++) begin
        host.wr(FGC_CFG_ADDR, (s == 1) ? (stk[i] | 16'h0004) : 16'h0000);
        thr[63-16*i -: 8] = 8'h10;
        meas[31-8*i -: 8] = 8'h20;
        wait_tick();
        chk(16'(flags[fl[i]]), 16'h0001);
        chk(16'(oe_n), 16'(s == 0));
        meas[31-8*i -: 8] = 8'h00;
        wait_tick();
        chk(16'(flags[fl[i]]), 16'(s));
        host.wr(FGC_STATUS_ADDR, 16'h0000);
        thr = THR_OFF;
        chk({5'h0, oe_n, flags}, 16'h0400);
      end
    end
    $display("test thresholds done");
  endtask

  // signed temperature limits, disable codes, sticky minimum flags
  task automatic t_signed();
    host.wr(FGC_CFG_ADDR, 16'h3000);
    meas.temp = 8'h80;
    wait_tick();
    meas.temp = 8'h7f;
    wait_tick();
    chk({6'h0, flags}, 16'h0000);
    thr.tmax = 8'h10;
    thr.tmin = 8'h10;
    thr.vmin = 8'h30;
    meas.temp = 8'hf0;
    meas.cell_v = 8'h20;
    wait_tick();
    chk({6'h0, flags}, 16'h0005);
    meas = '0;
    thr = THR_OFF;
    wait_tick();
    chk({6'h0, flags}, 16'h0005);
    host.wr(FGC_STATUS_ADDR, 16'h0000);
    chk({6'h0, flags}, 16'h0000);
    $display("test signed done");
  endtask

  // commanded power down, wake on a data edge, command bit clears
  task automatic t_cmd_pd();
    // hibernate setup sits outside this block and is taken as cleared
    host.wr(FGC_CFG_ADDR, 16'h0080);
    wait_pd(1'b1, 19, 23);
    sda = 1'b0;
    wait_pd(1'b0, 1, 3);
    sda = 1'b1;
    host.rd(FGC_CFG_ADDR, v);
    chk(v, 16'h0000);
    $display("test command shutdown done");
  endtask

  // removal power down, insertion wake, both cell alerts
  task automatic t_removal();
    host.wr(FGC_CFG_ADDR, 16'h0403);
    sense = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({4'h0, pin, oe_n, flags}, 16'h0200);
    wait_pd(1'b1, 17, 23);
    sense = 1'b0;
    wait_pd(1'b0, 1, 3);
    @(negedge clk_sys_i);
    chk({4'h0, pin, oe_n, flags}, 16'h0300);
    host.rd(FGC_STATUS_ADDR, v);
    chk(v, 16'h0300);
    host.wr(FGC_STATUS_ADDR, 16'h0100);
    chk({6'h0, flags}, 16'h0100);
    host.wr(FGC_STATUS_ADDR, 16'h0000);
    $display("test removal done");
  endtask

  // idle bus power down, wake on a clock rise
  task automatic t_bus_idle();
    host.wr(FGC_CFG_ADDR, 16'h0040);
    scl = 1'b0;
    sda = 1'b0;
    wait_pd(1'b1, 19, 23);
    scl = 1'b1;
    wait_pd(1'b0, 1, 3);
    sda = 1'b1;
    $display("test bus idle done");
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence, ending with a second reset
  initial begin
    t_reset();
    t_outputs();
    t_thresh();
    t_signed();
    t_cmd_pd();
    t_removal();
    t_bus_idle();
    t_reset();
    print_verdict();
  end

  // watchdog, well past the expected run of a few hundred cycles
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule

`default_nettype wire

// File: design/fgc_config_alert.sv
/*
  fgc_config_alert: configuration register, alert flags, alert pin gating
  and power-down sequencing of the fuel-gauge core.
  Assumes all inputs synchronous to clk_sys_i; measurement readings and
  thresholds come from neighbouring logic; register port is the internal
  side of the serial host interface.
*/
`timescale 1ns/100ps
`default_nettype none

module fgc_config_alert
  import fgc_pkg::*;
#(
  parameter logic [31:0] PD_DELAY_CYC = 32'(FGC_PD_DELAY_S * FGC_CLK_HZ),
  parameter logic [31:0] TASK_CYC = 32'(FGC_TASK_PERIOD_MS * FGC_CLK_HZ / 1000)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire fgc_meas_s meas_i,
  input wire fgc_thr_s thr_i,
  input wire logic analog_sense_input_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic alert_pin_out_o,
  output logic alert_pin_oe_n_o,
  output logic power_down_o,
  output logic task_tick_o,
  output logic temp_source_ext_o,
  output logic host_temp_o,
  output logic temp_measure_en_o,
  output logic thermistor_measure_on_o,
  output logic bias_switch_force_o,
  output logic [9:0] status_flags_o
);

  // ----------------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------------
  fgc_regs_s q_r;
  fgc_regs_s q_nxt;
  logic [7:0] raw_viol;
  logic [7:0] sticky;
  logic tick;
  logic cfg_wr;
  logic stat_wr;
  logic pd_cond;
  logic wake;
  logic scl_rise;
  logic sda_rise;
  logic sda_edge;
  logic thr_alert;

  assign cfg_wr = reg_wr_i && (reg_addr_i == FGC_CFG_ADDR);
  assign stat_wr = reg_wr_i && (reg_addr_i == FGC_STATUS_ADDR);
  assign tick = (q_r.task_cnt == TASK_CYC - 32'h1);
  assign scl_rise = scl_i && !q_r.scl_q;
  assign sda_rise = sda_i && !q_r.sda_q;
  assign sda_edge = sda_i != q_r.sda_q;

  // threshold comparisons, unsigned voltage/charge, signed temp/current
  always_comb begin
    raw_viol = 8'h00;
    raw_viol[FGC_F_VMX] = (thr_i.vmax != FGC_UMAX_OFF) && (meas_i.cell_v > thr_i.vmax);
    raw_viol[FGC_F_VMN] = (thr_i.vmin != FGC_UMIN_OFF) && (meas_i.cell_v < thr_i.vmin);
    raw_viol[FGC_F_TMX] = (thr_i.tmax != FGC_SMAX_OFF)
                          && ($signed(meas_i.temp) > $signed(thr_i.tmax));
    raw_viol[FGC_F_TMN] = (thr_i.tmin != FGC_SMIN_OFF)
                          && ($signed(meas_i.temp) < $signed(thr_i.tmin));
    raw_viol[FGC_F_SMX] = (thr_i.smax != FGC_UMAX_OFF) && (meas_i.soc > thr_i.smax);
    raw_viol[FGC_F_SMN] = (thr_i.smin != FGC_UMIN_OFF) && (meas_i.soc < thr_i.smin);
    raw_viol[FGC_F_IMX] = (thr_i.imax != FGC_SMAX_OFF)
                          && ($signed(meas_i.curr) > $signed(thr_i.imax));
    raw_viol[FGC_F_IMN] = (thr_i.imin != FGC_SMIN_OFF)
                          && ($signed(meas_i.curr) < $signed(thr_i.imin));
  end

  // per-flag sticky selection
  always_comb begin
    sticky = 8'h00;
    sticky[FGC_F_VMX] = q_r.cfg[FGC_B_VOLT_STK];
    sticky[FGC_F_VMN] = q_r.cfg[FGC_B_VOLT_STK];
    sticky[FGC_F_TMX] = q_r.cfg[FGC_B_TEMP_STK];
    sticky[FGC_F_TMN] = q_r.cfg[FGC_B_TEMP_STK];
    sticky[FGC_F_SMX] = q_r.cfg[FGC_B_SOC_STK];
    sticky[FGC_F_SMN] = q_r.cfg[FGC_B_SOC_STK];
    sticky[FGC_F_IMX] = q_r.cfg[FGC_B_CURR_STK];
    sticky[FGC_F_IMN] = q_r.cfg[FGC_B_CURR_STK];
  end

  // power-down and wake conditions
  assign pd_cond = q_r.cfg[FGC_B_PD_REQ]
                   || (q_r.cfg[FGC_B_RMV_PD] && analog_sense_input_i)
                   || (q_r.cfg[FGC_B_BUS_PD] && !scl_i && !sda_i);
  assign wake = (q_r.cfg[FGC_B_RMV_PD] && !analog_sense_input_i)
                || (q_r.cfg[FGC_B_BUS_PD] && (scl_rise || sda_rise))
                || (!q_r.cfg[FGC_B_RMV_PD] && !q_r.cfg[FGC_B_BUS_PD] && sda_edge);

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.sense_q = analog_sense_input_i;
    q_nxt.scl_q = scl_i;
    q_nxt.sda_q = sda_i;
    q_nxt.task_cnt = tick ? 32'h0 : q_r.task_cnt + 32'h1;
    // register writes take effect on the next edge, well inside a task period
    if (cfg_wr) begin
      q_nxt.cfg = reg_wdata_i & FGC_CFG_WMASK;
    end
    // writing zero to a status bit clears it
    if (stat_wr) begin
      q_nxt.flags = q_r.flags & reg_wdata_i[9:0];
    end
    // threshold flags refresh each task period, set wins over clear
    if (tick) begin
      for (int i = 0; i < 8; i++) begin
        q_nxt.flags[i] = raw_viol[i] || (sticky[i] && q_nxt.flags[i]);
      end
    end
    // insertion and removal events from the sense pin
    if (!analog_sense_input_i && q_r.sense_q) begin
      q_nxt.flags[FGC_F_INS] = 1'b1;
    end
    if (analog_sense_input_i && !q_r.sense_q) begin
      q_nxt.flags[FGC_F_RMV] = 1'b1;
    end
    // power-down sequencing
    case (q_r.st)
      FGC_ACTIVE: begin
        q_nxt.timer = 32'h0;
        if (pd_cond) begin
          q_nxt.st = FGC_PENDING;
        end
      end
      FGC_PENDING: begin
        if (!pd_cond) begin
          q_nxt.st = FGC_ACTIVE;
        end else if (q_r.timer >= PD_DELAY_CYC - 32'h1) begin
          q_nxt.st = FGC_SHUTDOWN;
        end else begin
          q_nxt.timer = q_r.timer + 32'h1;
        end
      end
      FGC_SHUTDOWN: begin
        if (wake) begin
          q_nxt.st = FGC_ACTIVE;
          q_nxt.cfg[FGC_B_PD_REQ] = 1'b0;
        end
      end
      default: begin
        q_nxt.st = FGC_ACTIVE;
      end
    endcase
    // read data
    if (reg_rd_i) begin
      case (reg_addr_i)
        FGC_CFG_ADDR: q_nxt.rdata = q_r.cfg;
        FGC_STATUS_ADDR: q_nxt.rdata = {6'h00, q_r.flags};
        default: q_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q_r.cfg <= FGC_CFG_RST;
      q_r.flags <= FGC_FLAGS_RST;
      q_r.st <= FGC_ACTIVE;
      q_r.timer <= 32'h0;
      q_r.task_cnt <= 32'h0;
      q_r.sense_q <= 1'b0;
      q_r.scl_q <= 1'b1;
      q_r.sda_q <= 1'b1;
      q_r.rdata <= 16'h0000;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // alert pin pulls low while any enabled alert stands
  assign thr_alert = q_r.cfg[FGC_B_ALERT_EN] && (|q_r.flags[7:0]);
  assign alert_pin_out_o = 1'b0;
  assign alert_pin_oe_n_o = !(thr_alert
                              || (q_r.cfg[FGC_B_INS_ALERT] && q_r.flags[FGC_F_INS])
                              || (q_r.cfg[FGC_B_RMV_ALERT] && q_r.flags[FGC_F_RMV]));
  assign reg_rdata_o = q_r.rdata;
  assign power_down_o = (q_r.st == FGC_SHUTDOWN);
  assign task_tick_o = tick;
  assign temp_source_ext_o = q_r.cfg[FGC_B_TSRC];
  assign host_temp_o = q_r.cfg[FGC_B_HOST_TEMP];
  assign temp_measure_en_o = q_r.cfg[FGC_B_TEMP_EN]
                             && (q_r.cfg[FGC_B_THRM_ON] || q_r.cfg[FGC_B_BIAS_FORCE]);
  assign thermistor_measure_on_o = q_r.cfg[FGC_B_THRM_ON];
  assign bias_switch_force_o = q_r.cfg[FGC_B_BIAS_FORCE];
  assign status_flags_o = q_r.flags;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_cfg_write_lands: assert property (
    cfg_wr && !(q_r.st == FGC_SHUTDOWN) |=> q_r.cfg == ($past(reg_wdata_i) & FGC_CFG_WMASK)
  ) else $error("config write not stored");

  a_temp_measure_gate: assert property (
    cfg_wr |=> temp_measure_en_o == ($past(reg_wdata_i[FGC_B_TEMP_EN])
        && ($past(reg_wdata_i[FGC_B_THRM_ON]) || $past(reg_wdata_i[FGC_B_BIAS_FORCE])))
  ) else $error("temperature measurement enable does not follow its enables");

  a_alert_pin_quiet: assert property (
    !q_r.cfg[FGC_B_ALERT_EN] && !q_r.cfg[FGC_B_INS_ALERT] && !q_r.cfg[FGC_B_RMV_ALERT]
    |-> alert_pin_oe_n_o
  ) else $error("alert pin driven while all alert enables off");

  a_flag_ignores_pin: assert property (
    tick && !stat_wr && !cfg_wr && !q_r.cfg[FGC_B_ALERT_EN] && raw_viol[FGC_F_VMX]
    |=> status_flags_o[FGC_F_VMX] && alert_pin_oe_n_o == !(q_r.cfg[FGC_B_INS_ALERT]
        && q_r.flags[FGC_F_INS] || q_r.cfg[FGC_B_RMV_ALERT] && q_r.flags[FGC_F_RMV])
  ) else $error("voltage max flag missed while pin disabled");

  a_volt_sticky_hold: assert property (
    tick && q_r.cfg[FGC_B_VOLT_STK] && q_r.flags[FGC_F_VMN] && !stat_wr
    |=> q_r.flags[FGC_F_VMN]
  ) else $error("sticky voltage flag dropped");

  a_soc_self_clear: assert property (
    tick && !q_r.cfg[FGC_B_SOC_STK] && !raw_viol[FGC_F_SMX] |=> !q_r.flags[FGC_F_SMX]
  ) else $error("self clearing charge flag did not clear");

  a_wake_sda_edge: assert property (
    q_r.st == FGC_SHUTDOWN && !q_r.cfg[FGC_B_RMV_PD] && !q_r.cfg[FGC_B_BUS_PD]
    && (sda_i != q_r.sda_q) |=> !power_down_o ##0 !q_r.cfg[FGC_B_PD_REQ]
  ) else $error("no wake on data line edge");

  a_pd_after_delay: assert property (
    q_r.st == FGC_PENDING && pd_cond && q_r.timer == PD_DELAY_CYC - 32'h1 |=> power_down_o
  ) else $error("power down missed at delay expiry");

  a_pd_not_early: assert property (
    q_r.st != FGC_SHUTDOWN && q_r.timer < PD_DELAY_CYC - 32'h1 |=> !power_down_o
  ) else $error("power down without delay");

  a_wake_clears_req: assert property (
    $fell(power_down_o) |-> !q_r.cfg[FGC_B_PD_REQ]
  ) else $error("power down request survived wake");

  a_wake_on_insert: assert property (
    q_r.st == FGC_SHUTDOWN && q_r.cfg[FGC_B_RMV_PD] && !analog_sense_input_i |=> !power_down_o
  ) else $error("no wake on cell insertion");

  a_insert_flag_set: assert property (
    !analog_sense_input_i && q_r.sense_q |=> status_flags_o[FGC_F_INS]
  ) else $error("insertion flag not set on sense fall");

  c_shutdown_entry: cover property (q_r.st == FGC_PENDING ##1 power_down_o);
  c_wake_by_sense: cover property (power_down_o && q_r.cfg[FGC_B_RMV_PD] ##1 !power_down_o);
  c_alert_pin_low: cover property ($fell(alert_pin_oe_n_o));
  c_status_cleared: cover property (stat_wr && |q_r.flags);
  c_wake_by_bus: cover property (power_down_o && q_r.cfg[FGC_B_BUS_PD] ##1 !power_down_o);

endmodule
`default_nettype wire

// File: include/fgc_pkg.sv
/*
  fgc_pkg: constants, field positions and carrier types for the fuel-gauge
  configuration and alert control block.
  Assumes a single 50 MHz system clock and byte-wide measurement readings.
*/
package fgc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] FGC_STATUS_ADDR = 8'h00;
  localparam logic [7:0] FGC_CFG_ADDR = 8'h1d;
  localparam logic [15:0] FGC_CFG_RST = 16'h2200; // temp sticky, temp enable set but measurement off (no thermistor or bias bit)
  localparam logic [15:0] FGC_CFG_WMASK = 16'hffdf; // reserved bit never stored
  localparam logic [9:0] FGC_FLAGS_RST = 10'h000;

  // configuration field positions
  localparam int FGC_B_TSRC = 15;
  localparam int FGC_B_SOC_STK = 14;
  localparam int FGC_B_TEMP_STK = 13;
  localparam int FGC_B_VOLT_STK = 12;
  localparam int FGC_B_CURR_STK = 11;
  localparam int FGC_B_RMV_PD = 10;
  localparam int FGC_B_TEMP_EN = 9;
  localparam int FGC_B_HOST_TEMP = 8;
  localparam int FGC_B_PD_REQ = 7;
  localparam int FGC_B_BUS_PD = 6;
  localparam int FGC_B_THRM_ON = 4;
  localparam int FGC_B_BIAS_FORCE = 3;
  localparam int FGC_B_ALERT_EN = 2;
  localparam int FGC_B_INS_ALERT = 1;
  localparam int FGC_B_RMV_ALERT = 0;

  // status flag positions
  localparam int FGC_F_VMN = 0;
  localparam int FGC_F_VMX = 1;
  localparam int FGC_F_TMN = 2;
  localparam int FGC_F_TMX = 3;
  localparam int FGC_F_SMN = 4;
  localparam int FGC_F_SMX = 5;
  localparam int FGC_F_IMN = 6;
  localparam int FGC_F_IMX = 7;
  localparam int FGC_F_INS = 8;
  localparam int FGC_F_RMV = 9;

  // threshold values that switch a check off
  localparam logic [7:0] FGC_UMAX_OFF = 8'hff;
  localparam logic [7:0] FGC_UMIN_OFF = 8'h00;
  localparam logic [7:0] FGC_SMAX_OFF = 8'h7f;
  localparam logic [7:0] FGC_SMIN_OFF = 8'h80;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint FGC_CLK_HZ = 50_000_000;
  localparam longint FGC_PD_DELAY_S = 45;
  localparam longint FGC_TASK_PERIOD_MS = 175;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FGC_ACTIVE = 2'h0,
    FGC_PENDING = 2'h1,
    FGC_SHUTDOWN = 2'h3
  } fgc_state_e;

  typedef struct packed {
    logic [7:0] cell_v;
    logic [7:0] temp;
    logic [7:0] soc;
    logic [7:0] curr;
  } fgc_meas_s;

  typedef struct packed {
    logic [7:0] vmax;
    logic [7:0] vmin;
    logic [7:0] tmax;
    logic [7:0] tmin;
    logic [7:0] smax;
    logic [7:0] smin;
    logic [7:0] imax;
    logic [7:0] imin;
  } fgc_thr_s;

  typedef struct packed {
    logic [15:0] cfg;
    logic [9:0] flags;
    fgc_state_e st;
    logic [31:0] timer;
    logic [31:0] task_cnt;
    logic sense_q;
    logic scl_q;
    logic sda_q;
    logic [15:0] rdata;
  } fgc_regs_s;

endpackage
